// file: dv/exec_checker.sv
// Purpose: port assertions for the execute stage
// Assumes: default widths, one clock
// Notes:   taken means valid while not busy
`timescale 1ns/1ns
module exec_checker (
  input wire CLK_IN, SYS_RST_IN, INSTR_VALID_IN, DEST_IN, BUSY_OUT,
  input wire FILE_WE_OUT, ZERO_FLAG_OUT, PC_LOAD_OUT, SKIP_OUT,
  input wire [2:0] OPCODE_IN,
  input wire [10:0] JUMP_ADDR_IN,
  input wire [7:0] LITERAL_IN, FILE_RDATA_IN, UPPER_POINTER_LATCH_IN,
  input wire [7:0] FILE_WDATA_OUT, ACC_OUT,
  input wire [14:0] PC_OUT
);
  // operand views, sampled one edge before the answer
  wire tk = INSTR_VALID_IN & ~BUSY_OUT;
  wire [7:0] dn = FILE_RDATA_IN - 8'h01;
  wire [7:0] up = FILE_RDATA_IN + 8'h01;
  wire [7:0] orv = ACC_OUT | LITERAL_IN;
  wire sk = OPCODE_IN == 3'h2 | OPCODE_IN == 3'h5;
  wire sz = OPCODE_IN == 3'h2 ? dn == 8'h00 : up == 8'h00;
  wire [14:0] tgt = {UPPER_POINTER_LATCH_IN[6:3], JUMP_ADDR_IN};
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (SYS_RST_IN);
  // a two-cycle form blocks exactly one slot
  sequence two_slot;
    BUSY_OUT ##1 !BUSY_OUT;
  endsequence
  jump_target_a:
    assert property (tk && OPCODE_IN == 3'h3 |=> PC_OUT == $past(tgt))
      else $error("jump target wrong");
  jump_cycles_a:
    assert property (tk && OPCODE_IN == 3'h3 |=> PC_LOAD_OUT ##0 two_slot)
      else $error("jump slot count wrong");
  jump_flags_a:
    assert property (tk && OPCODE_IN == 3'h3 |=> $stable(ZERO_FLAG_OUT))
      else $error("jump touched zero flag");
  dec_file_a:
    assert property (tk && OPCODE_IN == 3'h1 && DEST_IN |=> FILE_WE_OUT
      && FILE_WDATA_OUT == $past(dn) && ZERO_FLAG_OUT == !FILE_WDATA_OUT)
      else $error("decrement to file wrong");
  inc_acc_a:
    assert property (tk && OPCODE_IN == 3'h4 && !DEST_IN |=> !FILE_WE_OUT
      && ACC_OUT == $past(up) && ZERO_FLAG_OUT == !ACC_OUT)
      else $error("increment to acc wrong");
  or_lit_a:
    assert property (tk && OPCODE_IN == 3'h6 |=> ACC_OUT == $past(orv)
      && ZERO_FLAG_OUT == !ACC_OUT)
      else $error("or literal wrong");
  skip_taken_a:
    assert property (tk && sk && sz |=> SKIP_OUT ##0 two_slot)
      else $error("skip not taken");
  skip_flag_a:
    assert property (tk && sk |=> $stable(ZERO_FLAG_OUT)
      && SKIP_OUT == $past(sz))
      else $error("skip flag or pulse wrong");
  held_slot_a:
    assert property (BUSY_OUT |=> !FILE_WE_OUT && !PC_LOAD_OUT && !SKIP_OUT
      && $stable(ACC_OUT) && $stable(ZERO_FLAG_OUT))
      else $error("busy slot took an instruction");
endmodule
bind inc_dec_skip_jump_or_exec exec_checker i_chk (.*);

// file: dv/inc_dec_skip_jump_or_exec_tb.sv
// Purpose: random and corner runs of the execute stage
// Assumes: bench keeps its own acc and zero flag
// Notes:   drives at falling edge, checks one cycle later
`timescale 1ns/1ns
module inc_dec_skip_jump_or_exec_tb;
  reg clk = 0, rst = 1, dst = 0, v = 1;
  reg [2:0] op = 0;
  reg [6:0] fa = 0;
  reg [10:0] ja = 0;
  reg [7:0] k = 0, fr = 0, ul = 0, acc = 0, r;
  reg z = 0, bz = 0;
  reg [31:0] seed = 32'h914BCA00;
  integer failures = 0, compares = 0, i;
  wire busy, we, pl, sk, zf;
  wire [7:0] wd, ac;
  wire [6:0] wa;
  wire [14:0] pc;
  // 50 ns clock
  always #25 clk = ~clk;
  inc_dec_skip_jump_or_exec i_dut (.CLK_IN(clk), .SYS_RST_IN(rst),
    .INSTR_VALID_IN(v), .OPCODE_IN(op), .FILE_ADDR_IN(fa), .DEST_IN(dst),
    .JUMP_ADDR_IN(ja), .LITERAL_IN(k), .FILE_RDATA_IN(fr), .BUSY_OUT(busy),
    .UPPER_POINTER_LATCH_IN(ul), .FILE_WADDR_OUT(wa), .FILE_WDATA_OUT(wd),
    .FILE_WE_OUT(we), .ACC_OUT(ac), .ZERO_FLAG_OUT(zf), .PC_OUT(pc),
    .PC_LOAD_OUT(pl), .SKIP_OUT(sk));
  // xorshift step for repeatable stimulus
  function [31:0] xs(input [31:0] s);
    xs = s ^ (s << 13);
    xs = xs ^ (xs >> 17);
    xs = xs ^ (xs << 5);
  endfunction
  task chk(input string n, input logic [31:0] s, e);
    compares = compares + 1;
    if (s !== e)
    begin
      failures = failures + 1;
      $display("MISMATCH %s exp %h seen %h", n, e, s);
    end
  endtask
  // one instruction; busy slot ones must be ignored
  task step(input [2:0] o, input [7:0] f, input d);
    seed = xs(seed);
    {fa, ja, k, ul} = {seed[31:30], seed};
    {op, fr, dst} = {o, f, d};
    r = o < 3 ? f - 8'h01 : f + 8'h01;
    @(negedge clk);
    if (bz || !v)
      chk("held", {we, pl, sk, ac, zf}, {3'h0, acc, z});
    else if (o == 3)
      chk("jump", {pl, pc, zf}, {1'h1, ul[6:3], ja, z});
    else if (o == 6)
    begin
      acc = acc | k;
      z = acc == 0;
      chk("or", {ac, zf}, {acc, z});
    end
    else if (o != 0 && o != 7)
    begin
      z = (o == 1 || o == 4) ? r == 0 : z;
      acc = d ? acc : r;
      chk("step", {we, ac, zf}, {d, acc, z});
      chk("skip", sk, (o == 2 || o == 5) && r == 0);
      if (d)
      begin
        chk("wdata", wd, r);
        chk("waddr", wa, fa);
      end
    end
    bz = !bz && v && (o == 3 || (o == 2 || o == 5) && !r);
    chk("busy", busy, bz);
  endtask
  task stop_test;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // corners first, then random traffic
  initial
  begin
    repeat (10) @(negedge clk);
    rst = 0;
    step(1, 8'h01, 0);
    step(5, 8'hFF, 1);
    step(3, 8'h00, 0);
    step(3, 8'h00, 0);
    step(2, 8'h01, 0);
    step(2, 8'h01, 1);
    step(4, 8'hFF, 1);
    step(4, 8'hFF, 1);
    step(1, 8'h00, 0);
    step(7, 8'h00, 0);
    $display("corner test done");
    for (i = 0; i < 300; i = i + 1)
    begin
      seed = xs(seed);
      v = seed[7] | seed[6];
      step(seed[2:0], seed[4] ? seed[15:8] : {8{seed[3]}}, seed[5]);
    end
    $display("random test done");
    stop_test;
  end
  // hang guard, well past the expected run
  initial
  begin
    #100000;
    failures = failures + 1;
    stop_test;
  end
endmodule

// file: src/exec_defs.vh
// Purpose: shared constants for the inc/dec/skip/jump/or execute datapath
// Assumes: 8-bit data, 7-bit file address, 15-bit program counter
// Notes:   opcode codes are local to this core's decoder interface
`ifndef EXEC_DEFS_VH
`define EXEC_DEFS_VH

// operation select codes from the decoder
`define OP_NONE          3'h0
`define OP_FILE_MINUS    3'h1
`define OP_FILE_MINUS_SZ 3'h2
`define OP_JUMP_ABS      3'h3
`define OP_FILE_PLUS     3'h4
`define OP_FILE_PLUS_SZ  3'h5
`define OP_OR_LITERAL    3'h6

// destination bit values
`define DEST_ACC         1'h0
`define DEST_FILE        1'h1

// widths
`define DATA_W           8
`define FADDR_W          7
`define PC_W             15
`define JUMP_W           11
`define OPCODE_W         3

// upper pointer latch source field for the jump
`define LATCH_HI         6
`define LATCH_LO         3

// reset values
`define DATA_RST         8'h00
`define PC_RST           15'h0000
`define ZERO_RST         1'h0
`define STEP_ONE         8'h01

// execute sequencer states
`define ST_EXEC          1'h0
`define ST_IDLE_SLOT     1'h1

`endif

// file: src/inc_dec_skip_jump_or_exec.v
// Purpose: execute stage for file +/-1 (with skip), absolute jump, OR literal
// Assumes: one instruction presented per cycle with INSTR_VALID_IN; file
//          read data arrives combinationally for the given address
// Notes:   two-cycle instructions raise BUSY_OUT; the decoder holds off
//          and any instruction offered during that slot is ignored.
//          accumulator and zero flag live here and are shown on ports;
//          file writes, jump loads and skips leave as one-cycle strobes
//          so the fetch unit keeps ownership of the program counter.
//          skip forms keep the zero flag, unlike the plain inc/dec forms,
//          so a counted loop does not disturb flags set before it.
//          jump upper bits use the wide latch field, not the narrow one.
// Operation
// [RL1] decrement file, update zero flag, result to acc (d=0) or file (d=1)
// [RL2] decrement-skip: store per d; zero result replaces next with idle slot
// [RL3] jump loads 11-bit immediate into counter bits 10..0
// [RL4] jump fills counter bits 14..11 from latch bits 6..3
// [RL5] jump always takes two cycles and leaves flags alone
// [RL6] increment file, update zero flag, result to acc or file by d
// [RL7] increment-skip: store per d, flags untouched, zero result skips next
// [RL8] OR literal into accumulator and update zero flag
// [RL9] skipped instruction is fetched then discarded, idle slot executed
// [RL10] inc/dec wrap modulo 256; zero flag set exactly on all-zero result
`timescale 1ns/1ns
`include "exec_defs.vh"

module inc_dec_skip_jump_or_exec
#(
  parameter DW = `DATA_W,
  parameter AW = `FADDR_W,
  parameter PW = `PC_W
)
(
  input  wire                  CLK_IN,
  input  wire                  SYS_RST_IN,
  input  wire                  INSTR_VALID_IN,
  input  wire [`OPCODE_W-1:0]  OPCODE_IN,
  input  wire [AW-1:0]         FILE_ADDR_IN,
  input  wire                  DEST_IN,
  input  wire [`JUMP_W-1:0]    JUMP_ADDR_IN,
  input  wire [DW-1:0]         LITERAL_IN,
  input  wire [DW-1:0]         FILE_RDATA_IN,
  input  wire [DW-1:0]         UPPER_POINTER_LATCH_IN,
  output wire                  BUSY_OUT,
  output reg  [AW-1:0]         FILE_WADDR_OUT,
  output reg  [DW-1:0]         FILE_WDATA_OUT,
  output reg                   FILE_WE_OUT,
  output reg  [DW-1:0]         ACC_OUT,
  output reg                   ZERO_FLAG_OUT,
  output reg  [PW-1:0]         PC_OUT,
  output reg                   PC_LOAD_OUT,
  output reg                   SKIP_OUT
);

  // decode helpers used in several places; kept as functions so the
  // sequencer and the output processes cannot drift apart
  function is_step;
    input [`OPCODE_W-1:0] op;
    begin
      is_step = (op == `OP_FILE_MINUS) || (op == `OP_FILE_MINUS_SZ) ||
                (op == `OP_FILE_PLUS)  || (op == `OP_FILE_PLUS_SZ);
    end
  endfunction

  function is_skip;
    input [`OPCODE_W-1:0] op;
    begin
      is_skip = (op == `OP_FILE_MINUS_SZ) || (op == `OP_FILE_PLUS_SZ);
    end
  endfunction

  function is_jump;
    input [`OPCODE_W-1:0] op;
    begin
      is_jump = (op == `OP_JUMP_ABS);
    end
  endfunction

  // sequencer state and its next value
  reg           state_r;
  reg           state_nxt;
  // step unit operands and results
  wire          step_down;
  wire [DW-1:0] step_res;
  wire          step_zero;
  // per-class take strobes
  wire          take;
  wire          take_step;
  wire          take_jump;
  wire          take_or;
  wire          skip_hit;
  wire [DW-1:0] or_res;

  // direction of the shared step unit
  assign step_down = (OPCODE_IN == `OP_FILE_MINUS) ||
                     (OPCODE_IN == `OP_FILE_MINUS_SZ);
  // OR result settles before the edge; only take_or commits it
  assign or_res    = ACC_OUT | LITERAL_IN;                  // [RL8]
  // an instruction is taken only in the execute state
  assign take      = INSTR_VALID_IN && (state_r == `ST_EXEC);
  // one strobe per instruction class; each output process keys on one or two
  assign take_step = take && is_step(OPCODE_IN);
  assign take_jump = take && is_jump(OPCODE_IN);
  assign take_or   = take && (OPCODE_IN == `OP_OR_LITERAL);
  // a skip form whose result is zero throws away the next word
  assign skip_hit  = take_step && is_skip(OPCODE_IN) && step_zero; // [RL2]
  // busy during the second cycle of a jump or skip; taken straight
  // from the state register so the decoder sees it early in the cycle
  assign BUSY_OUT  = (state_r == `ST_IDLE_SLOT);

  // shared plus/minus one; wraps, so zero minus one gives all ones
  step_unit #(
    .WIDTH      (DW)
  ) u_step (
    .operand_in (FILE_RDATA_IN),
    .down_in    (step_down),
    .result_out (step_res),                                 // [RL10]
    .zero_out   (step_zero)
  );

  // sequencer: two-cycle ops park one cycle in the idle slot
  always @*
  begin
    state_nxt = `ST_EXEC;
    case (state_r)
      `ST_EXEC:
      begin
        if (take_jump)
          state_nxt = `ST_IDLE_SLOT;                        // [RL5]
        else if (skip_hit)
          state_nxt = `ST_IDLE_SLOT;                        // [RL2] [RL7]
      end
      // one idle cycle only; no instruction is taken in it
      `ST_IDLE_SLOT:
        state_nxt = `ST_EXEC;                               // [RL9]
      default:
        state_nxt = `ST_EXEC;
    endcase
  end

  // sequencer state register
  always @(posedge CLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
      state_r <= `ST_EXEC;
    else
      state_r <= state_nxt;
  end

  // accumulator: step results with d=0 and the OR literal land here;
  // nothing else in this block writes it
  always @(posedge CLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
      ACC_OUT <= `DATA_RST;
    else if (take_step && (DEST_IN == `DEST_ACC))
      ACC_OUT <= step_res;                                  // [RL1] [RL6]
    else if (take_or)
      ACC_OUT <= or_res;                                    // [RL8]
  end

  // zero flag: plain inc/dec and OR only; the skip forms and the jump
  // leave it, so a loop counter does not clobber an earlier test
  always @(posedge CLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
      ZERO_FLAG_OUT <= `ZERO_RST;
    else if (take_step && !is_skip(OPCODE_IN))
      ZERO_FLAG_OUT <= step_zero;                           // [RL10]
    else if (take_or)
      ZERO_FLAG_OUT <= (or_res == `DATA_RST);               // [RL8]
  end

  // file write port: address and data hold, the strobe lasts one cycle;
  // skip forms write here too when d=1, before the skip takes effect
  always @(posedge CLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
    begin
      FILE_WADDR_OUT <= {AW{1'h0}};
      FILE_WDATA_OUT <= `DATA_RST;
      FILE_WE_OUT    <= 1'h0;
    end
    else if (take_step && (DEST_IN == `DEST_FILE))
    begin
      FILE_WADDR_OUT <= FILE_ADDR_IN;                       // [RL1] [RL6]
      FILE_WDATA_OUT <= step_res;                           // [RL2] [RL7]
      FILE_WE_OUT    <= 1'h1;
    end
    else
      FILE_WE_OUT    <= 1'h0;
  end

  // jump port: the target holds after the load pulse, so the fetch unit
  // may pick it up late without a second copy
  always @(posedge CLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
    begin
      PC_OUT      <= `PC_RST;
      PC_LOAD_OUT <= 1'h0;
    end
    else if (take_jump)
    begin
      // upper bits from the wider latch field; flags untouched
      PC_OUT      <= {UPPER_POINTER_LATCH_IN[`LATCH_HI:`LATCH_LO],
                      JUMP_ADDR_IN};                        // [RL3] [RL4]
      PC_LOAD_OUT <= 1'h1;                                  // [RL5]
    end
    else
      PC_LOAD_OUT <= 1'h0;
  end

  // skip pulse: the fetch unit drops the word already fetched and runs
  // an idle slot; the counter keeps its normal sequence
  always @(posedge CLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
      SKIP_OUT <= 1'h0;
    else
      SKIP_OUT <= skip_hit;                                 // [RL9]
  end

endmodule

// file: src/step_unit.v
// Purpose: plus/minus one with wrap and zero detection
// Assumes: purely combinational, used by the execute datapath
// Notes:   result wraps modulo 2^WIDTH
`timescale 1ns/1ns
`include "exec_defs.vh"

module step_unit
#(
  parameter WIDTH = `DATA_W
)
(
  input  wire [WIDTH-1:0] operand_in,
  input  wire             down_in,
  output wire [WIDTH-1:0] result_out,
  output wire             zero_out
);

  wire [WIDTH-1:0] one = {{(WIDTH-1){1'h0}}, 1'h1};

  // modulo arithmetic: the carry out is simply dropped
  assign result_out = down_in ? (operand_in - one) : (operand_in + one);
  assign zero_out   = (result_out == {WIDTH{1'h0}});

endmodule
